// file: inc/match_ctrl_pkg.sv
// Behaviour
// - Permit output runs continuous, delayed continuous or delayed pulse; continuous default.
// - Delayed continuous raises permit after settable delay, 5 ms steps, 50 ms default.
// - Delayed pulse drops permit after settable length, 5 ms steps, 50 ms default.
// - Each stage's status may be forced blocked or ok while forcing is enabled.
// - A selector picks bus or line as live/dead reference; line by default.
// - Every stage has its own enable, off by default; disabled stages never check.
// - In on-start mode a stage checks only while its start input is active.
// - First stage reference: none, three phase-phase, three phase-earth, subset by wiring.
// - Second stage takes phase-phase or none, only with channels three and four side.
// - Third stage is on when its reference is channel three versus four.
// - Automatic synchronized closing exists only on the first stage, off by default.
// - Outside test mode, with automatic closing on, the block closes the breaker once sides are synchronized.
// - The close command is advanced by a settable breaker time, 50 ms default.
// - The close command goes to one of five objects; the first by default.
// - Report estimated time until synchronism, up to 360 s in 5 ms steps.
// - Report the time of one full relative rotation, up to 360 s, 5 ms.
// - Report the present angle difference, -360 to +360 degrees, 0.001 degree.
// - Node mode on, blocked, test, test-blocked or off; settable only when allowed.
// - Blocking is sampled each program cycle; a blocked stage shows blocked once synchronized and permits only if forced ok.
package match_ctrl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROGRAM_CYCLE_NS = 5_000_000;
  localparam int CYCLE_CLKS = PROGRAM_CYCLE_NS / CLK_PERIOD_NS;
  localparam int STEP_MS = 5;
  localparam int SETTING_MAX_MS = 1_800_000;
  localparam int REPORT_MAX_MS = 360_000;
  localparam int TIME_DEFAULT_MS = 50;
  localparam int TIME_W = 19;
  localparam int REPORT_W = 17;
  localparam int ANGLE_W = 20;
  localparam int ADDR_W = 8;
  localparam logic [TIME_W-1:0] TIME_MAX_TICKS = TIME_W'(SETTING_MAX_MS / STEP_MS);
  localparam logic [TIME_W-1:0] TIME_DEF_TICKS = TIME_W'(TIME_DEFAULT_MS / STEP_MS);
  localparam logic [REPORT_W-1:0] REPORT_MAX_TICKS = REPORT_W'(REPORT_MAX_MS / STEP_MS);
  localparam logic [ANGLE_W-1:0] QUARTER_MDEG = 20'h1_5F90;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STAGE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DELAY = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PULSE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_BKTIME = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EST = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ROT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_ANGLE = 8'h20;
  localparam int POS_OPMODE = 0;
  localparam int POS_BEHAV = 4;
  localparam int POS_REFSEL = 8;
  localparam int POS_FORCE = 12;
  localparam int POS_EN = 0;
  localparam int POS_START = 4;
  localparam int POS_REF1 = 8;
  localparam int POS_REF2 = 12;
  localparam int POS_REF3 = 16;
  localparam int POS_SWITCH = 20;
  localparam int POS_OBJ = 24;
  localparam int POS_ST_PERMIT = 0;
  localparam int POS_ST_BLOCKED = 4;
  localparam int POS_ST_CHECK = 8;
  localparam int POS_ST_CLOSED = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] STAGE_RESET = 32'h0000_0000;
  localparam logic [2:0] REF1_LAST_PP = 3'h3;
  localparam logic [2:0] OBJ_LAST = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {BEH_CONT, BEH_DELAYED, BEH_PULSE} behaviour_t;
  typedef enum logic [2:0] {
    OPM_ON, OPM_BLOCKED, OPM_TEST, OPM_TEST_BLOCKED, OPM_OFF
  } opmode_t;
  typedef enum logic [2:0] {
    FRC_NORMAL, FRC_S1_BLK, FRC_S1_OK, FRC_S2_BLK, FRC_S2_OK, FRC_S3_BLK,
    FRC_S3_OK
  } force_t;
endpackage : match_ctrl_pkg

// file: rtl/cycle_divider.sv
`timescale 1ns/1ps
`default_nettype none
module cycle_divider #(
  parameter int unsigned DIV = match_ctrl_pkg::CYCLE_CLKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  import match_ctrl_pkg::*;
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_tick = (cnt_ff == LAST);
    nxt_cnt = nxt_tick ? '0 : cnt_ff + 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

  a_tick_single: assert property (@(posedge aclk) disable iff (!aresetn)
    (DIV > 1) && tick |=> !tick)
    else $error("Program cycle tick lasted more than one clock.");
endmodule : cycle_divider
`default_nettype wire

// file: rtl/permit_shaper.sv
`timescale 1ns/1ps
`default_nettype none
module permit_shaper #(
  parameter int TW = match_ctrl_pkg::TIME_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic active,
  input wire match_ctrl_pkg::behaviour_t behaviour,
  input wire logic [TW-1:0] delay_ticks,
  input wire logic [TW-1:0] pulse_ticks,
  output logic permit
);
  import match_ctrl_pkg::*;
  logic [TW-1:0] cnt_ff, nxt_cnt;
  logic permit_ff, nxt_permit;

  // The count saturates, so a long held condition never restarts a pulse.
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!active) begin
      nxt_cnt = '0;
    end else if (tick && cnt_ff != '1) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    case (behaviour)
      BEH_DELAYED: nxt_permit = active && nxt_cnt >= delay_ticks;
      BEH_PULSE: nxt_permit = active && nxt_cnt < pulse_ticks;
      default: nxt_permit = active;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
      permit_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      permit_ff <= nxt_permit;
    end
  end

  assign permit = permit_ff;

  a_cont_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    behaviour == BEH_CONT |=> permit == $past(active))
    else $error("Continuous permit does not follow the condition.");
  a_delay_wait: assert property (
    @(posedge aclk) disable iff (!aresetn)
    behaviour == BEH_DELAYED |=> !permit
    || (cnt_ff >= $past(delay_ticks) && $past(active)))
    else $error("Delayed permit raised before its delay.");
  a_pulse_end: assert property (
    @(posedge aclk) disable iff (!aresetn)
    behaviour == BEH_PULSE |=> !permit || cnt_ff < $past(pulse_ticks))
    else $error("Pulse permit outlived its length.");
  a_timer_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    !active |=> cnt_ff == '0 && !permit)
    else $error("Timer not restarted after the condition dropped.");
endmodule : permit_shaper
`default_nettype wire

// file: rtl/synchrocheck_stage_control.sv
`timescale 1ns/1ps
`default_nettype none
module synchrocheck_stage_control #(
  parameter int unsigned CYCLE_CLKS = match_ctrl_pkg::CYCLE_CLKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [match_ctrl_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [match_ctrl_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic block_input,
  input wire logic [2:0] sync_reached,
  input wire logic [2:0] check_start_input,
  input wire logic all_refs_allowed,
  input wire logic ch3_side_channel,
  input wire logic ch4_side_channel,
  input wire logic node_mode_allowed,
  input wire logic forcing_enable,
  input wire logic signed [match_ctrl_pkg::ANGLE_W-1:0] angle_mdeg,
  output logic [2:0] match_permit,
  output logic [2:0] stage_blocked,
  output logic line_is_reference,
  output logic [4:0] close_object_cmd
);
  import match_ctrl_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [TIME_W-1:0] clamp_time(input logic [31:0] v);
    return (v > 32'(TIME_MAX_TICKS)) ? TIME_MAX_TICKS : v[TIME_W-1:0];
  endfunction : clamp_time

  // Register bus state.
  logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata, rd_word;
  logic rd_hit;
  logic [31:0] ctrl_ff, nxt_ctrl, stage_ff, nxt_stage, cand;
  logic [TIME_W-1:0] delay_ff, nxt_delay, pulse_ff, nxt_pulse;
  logic [TIME_W-1:0] bktime_ff, nxt_bktime;
  logic aw_have, w_have, wr_fire, wr_hit;
  logic [ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  assign awready = !aw_hold_ff && !bvalid_ff;
  assign wready = !w_hold_ff && !bvalid_ff;
  assign arready = !rvalid_ff;
  assign aw_have = aw_hold_ff || (awvalid && awready);
  assign w_have = w_hold_ff || (wvalid && wready);
  assign wr_fire = aw_have && w_have;
  assign wa = aw_hold_ff ? awaddr_ff : awaddr;
  assign wd = w_hold_ff ? wdata_ff : wdata;
  assign ws = w_hold_ff ? wstrb_ff : wstrb;

  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_ctrl = ctrl_ff;
    nxt_stage = stage_ff;
    nxt_delay = delay_ff;
    nxt_pulse = pulse_ff;
    nxt_bktime = bktime_ff;
    wr_hit = 1'b1;
    cand = 32'h0000_0000;
    if (awvalid && awready) begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = wdata;
      nxt_wstrb = wstrb;
    end
    if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
    if (wr_fire) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      case (wa)
        OFS_CTRL: begin
          cand = merge(ctrl_ff, wd, ws);
          // Codes outside the documented sets leave the old choice standing.
          if (!node_mode_allowed || cand[POS_OPMODE +: 3] > 3'(OPM_OFF)) begin
            cand[POS_OPMODE +: 3] = ctrl_ff[POS_OPMODE +: 3];
          end
          if (cand[POS_BEHAV +: 2] > 2'(BEH_PULSE)) begin
            cand[POS_BEHAV +: 2] = ctrl_ff[POS_BEHAV +: 2];
          end
          if (cand[POS_FORCE +: 3] > 3'(FRC_S3_OK)) begin
            cand[POS_FORCE +: 3] = ctrl_ff[POS_FORCE +: 3];
          end
          nxt_ctrl = cand;
        end
        OFS_STAGE: begin
          cand = merge(stage_ff, wd, ws);
          if (!all_refs_allowed && cand[POS_REF1 +: 3] > REF1_LAST_PP) begin
            cand[POS_REF1 +: 3] = stage_ff[POS_REF1 +: 3];
          end
          if (cand[POS_REF1 +: 3] > 3'h6) begin
            cand[POS_REF1 +: 3] = stage_ff[POS_REF1 +: 3];
          end
          if (cand[POS_OBJ +: 3] > OBJ_LAST) begin
            cand[POS_OBJ +: 3] = stage_ff[POS_OBJ +: 3];
          end
          nxt_stage = cand;
        end
        OFS_DELAY: nxt_delay = clamp_time(merge(32'(delay_ff), wd, ws));
        OFS_PULSE: nxt_pulse = clamp_time(merge(32'(pulse_ff), wd, ws));
        OFS_BKTIME: nxt_bktime = clamp_time(merge(32'(bktime_ff), wd, ws));
        default: wr_hit = 1'b0;
      endcase
      nxt_bvalid = 1'b1;
      nxt_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      ctrl_ff <= CTRL_RESET;
      stage_ff <= STAGE_RESET;
      delay_ff <= TIME_DEF_TICKS;
      pulse_ff <= TIME_DEF_TICKS;
      bktime_ff <= TIME_DEF_TICKS;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      ctrl_ff <= nxt_ctrl;
      stage_ff <= nxt_stage;
      delay_ff <= nxt_delay;
      pulse_ff <= nxt_pulse;
      bktime_ff <= nxt_bktime;
    end
  end

  // Decoded settings.
  opmode_t opmode;
  behaviour_t behaviour;
  force_t force_sel;
  logic [2:0] stage_en, start_on_input, ref1;
  logic [1:0] ref2;
  logic ref3, switch_en;
  logic [2:0] obj_sel;

  assign opmode = node_mode_allowed ? opmode_t'(ctrl_ff[POS_OPMODE +: 3])
                                    : OPM_ON;
  assign behaviour = behaviour_t'(ctrl_ff[POS_BEHAV +: 2]);
  assign force_sel = forcing_enable ? force_t'(ctrl_ff[POS_FORCE +: 3])
                                    : FRC_NORMAL;
  assign line_is_reference = !ctrl_ff[POS_REFSEL];
  assign stage_en = stage_ff[POS_EN +: 3];
  assign start_on_input = stage_ff[POS_START +: 3];
  assign ref1 = stage_ff[POS_REF1 +: 3];
  assign ref2 = stage_ff[POS_REF2 +: 2];
  assign ref3 = stage_ff[POS_REF3];
  assign switch_en = stage_ff[POS_SWITCH];
  assign obj_sel = stage_ff[POS_OBJ +: 3];

  // Inputs are taken once per program cycle, as the relay firmware does.
  logic tick;
  logic block_s_ff, nxt_block_s;
  logic [2:0] sync_s_ff, nxt_sync_s, start_s_ff, nxt_start_s;
  logic signed [ANGLE_W-1:0] angle_ff, nxt_angle;

  cycle_divider #(.DIV(CYCLE_CLKS)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  always_comb begin
    nxt_block_s = tick ? block_input : block_s_ff;
    nxt_sync_s = tick ? sync_reached : sync_s_ff;
    nxt_start_s = tick ? check_start_input : start_s_ff;
    nxt_angle = tick ? angle_mdeg : angle_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_s_ff <= 1'b0;
      sync_s_ff <= 3'h0;
      start_s_ff <= 3'h0;
      angle_ff <= '0;
    end else begin
      block_s_ff <= nxt_block_s;
      sync_s_ff <= nxt_sync_s;
      start_s_ff <= nxt_start_s;
      angle_ff <= nxt_angle;
    end
  end

  // Stage qualification and permit shaping.
  logic [2:0] avail, checking, active, shaped;
  logic blocked_eff;

  assign avail[0] = stage_en[0] && ref1 != 3'h0;
  assign avail[1] = stage_en[1] && ref2 != 2'h0 && ch3_side_channel
                    && ch4_side_channel;
  assign avail[2] = stage_en[2] && ref3;
  assign blocked_eff = block_s_ff || opmode == OPM_BLOCKED
                       || opmode == OPM_TEST_BLOCKED;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_stage
      assign checking[g] = avail[g] && opmode != OPM_OFF
                           && (!start_on_input[g] || start_s_ff[g]);
      assign active[g] = checking[g] && sync_s_ff[g] && !blocked_eff;
      permit_shaper u_shaper (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .active(active[g]),
        .behaviour(behaviour),
        .delay_ticks(delay_ff),
        .pulse_ticks(pulse_ff),
        .permit(shaped[g])
      );
      always_comb begin
        match_permit[g] = shaped[g] && !blocked_eff;
        stage_blocked[g] = checking[g] && sync_s_ff[g] && blocked_eff;
        if (force_sel == force_t'(3'(2 * g + 1))) begin
          match_permit[g] = 1'b0;
          stage_blocked[g] = 1'b1;
        end else if (force_sel == force_t'(3'(2 * g + 2))) begin
          match_permit[g] = 1'b1;
          stage_blocked[g] = 1'b0;
        end
      end
    end
  endgenerate

  // Rotation is timed between zero crossings; the wrap near 180 deg is skipped.
  logic [REPORT_W-1:0] rot_ff, nxt_rot, since_ff, nxt_since, est;
  logic crossed, arm_ff, nxt_arm, closed_ff, nxt_closed, fire;
  logic [4:0] close_ff, nxt_close;
  logic [ANGLE_W-1:0] abs_now;

  assign abs_now = angle_mdeg[ANGLE_W-1] ? ANGLE_W'(-angle_mdeg)
                                         : ANGLE_W'(angle_mdeg);
  assign crossed = tick && (angle_ff[ANGLE_W-1] != angle_mdeg[ANGLE_W-1])
                   && abs_now < QUARTER_MDEG;
  assign est = (rot_ff > since_ff) ? rot_ff - since_ff : '0;
  assign fire = tick && arm_ff && switch_en && match_permit[0]
                && opmode != OPM_TEST && est <= REPORT_W'(bktime_ff > 
                TIME_W'(REPORT_MAX_TICKS) ? TIME_W'(REPORT_MAX_TICKS)
                : bktime_ff);

  always_comb begin
    nxt_rot = rot_ff;
    nxt_since = since_ff;
    if (crossed) begin
      nxt_rot = since_ff;
      nxt_since = '0;
    end else if (tick && since_ff < REPORT_MAX_TICKS) begin
      nxt_since = since_ff + 1'b1;
    end
    nxt_arm = arm_ff;
    if (!match_permit[0]) begin
      nxt_arm = 1'b1; // A close is issued once per synchronous episode.
    end else if (fire) begin
      nxt_arm = 1'b0;
    end
    nxt_close = 5'h00;
    if (fire) begin
      nxt_close = 5'(5'h01 << obj_sel);
    end
    nxt_closed = fire ? 1'b1 : closed_ff && switch_en;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rot_ff <= '0;
      since_ff <= '0;
      arm_ff <= 1'b1;
      close_ff <= 5'h00;
      closed_ff <= 1'b0;
    end else begin
      rot_ff <= nxt_rot;
      since_ff <= nxt_since;
      arm_ff <= nxt_arm;
      close_ff <= nxt_close;
      closed_ff <= nxt_closed;
    end
  end

  assign close_object_cmd = close_ff;

  // Read side.
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (araddr)
      OFS_CTRL: rd_word = ctrl_ff;
      OFS_STAGE: rd_word = stage_ff;
      OFS_DELAY: rd_word = 32'(delay_ff);
      OFS_PULSE: rd_word = 32'(pulse_ff);
      OFS_BKTIME: rd_word = 32'(bktime_ff);
      OFS_STATUS: begin
        rd_word[POS_ST_PERMIT +: 3] = match_permit;
        rd_word[POS_ST_BLOCKED +: 3] = stage_blocked;
        rd_word[POS_ST_CHECK +: 3] = checking;
        rd_word[POS_ST_CLOSED] = closed_ff;
      end
      OFS_EST: rd_word = 32'(est);
      OFS_ROT: rd_word = 32'(rot_ff);
      OFS_ANGLE: rd_word = 32'(angle_ff);
      default: rd_hit = 1'b0;
    endcase
    nxt_rvalid = rvalid_ff && !rready;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (arvalid && arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rd_word;
      nxt_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  sequence s_close_pulse;
    !arm_ff ##1 close_object_cmd == 5'h00;
  endsequence

  a_close_first: assert property (
    @(posedge aclk) disable iff (!aresetn) close_object_cmd != 5'h00
    |-> $past(tick && switch_en && match_permit[0] && arm_ff))
    else $error("Close issued without first stage synchronism.");
  a_close_once: assert property (
    @(posedge aclk) disable iff (!aresetn)
    close_object_cmd != 5'h00 |-> s_close_pulse)
    else $error("Close command not a single pulse.");
  a_close_advance: assert property (
    @(posedge aclk) disable iff (!aresetn) close_object_cmd != 5'h00
    |-> 32'($past(est)) <= 32'($past(bktime_ff)))
    else $error("Close issued earlier than the breaker time.");
  a_close_object: assert property (@(posedge aclk) disable iff (!aresetn)
    close_object_cmd != 5'h00 |-> $onehot(close_object_cmd)
    && close_object_cmd[$past(obj_sel)])
    else $error("Close routed to the wrong object.");
  a_block_excl: assert property (@(posedge aclk) disable iff (!aresetn)
    (match_permit & stage_blocked) == 3'h0)
    else $error("A stage shows permit and blocked together.");
  a_stage_idle: assert property (
    @(posedge aclk) disable iff (!aresetn)
    force_sel == FRC_NORMAL && !checking[0] ##1 force_sel == FRC_NORMAL
    |-> !match_permit[0])
    else $error("Disabled first stage raised its permit.");
  a_mode_off: assert property (@(posedge aclk) disable iff (!aresetn)
    opmode == OPM_OFF |-> checking == 3'h0)
    else $error("Checking while the node mode is off.");
  a_force_blk: assert property (@(posedge aclk) disable iff (!aresetn)
    force_sel == FRC_S2_BLK |-> stage_blocked[1] && !match_permit[1])
    else $error("Forced block not shown on the second stage.");
  a_start_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    start_on_input[2] && !start_s_ff[2] |-> !checking[2])
    else $error("Third stage checks without its start input.");
endmodule : synchrocheck_stage_control
`default_nettype wire

// file: verification/breaker_objects.sv
`timescale 1ns/1ps
`default_nettype none
module breaker_objects (
  input wire logic aclk,
  input wire logic [4:0] close_cmd,
  output var int closes [5]
);
  initial begin
    for (int i = 0; i < 5; i++) closes[i] = 0;
  end
  always @(posedge aclk) begin
    for (int i = 0; i < 5; i++)
      if (close_cmd[i] === 1'h1) closes[i] <= closes[i] + 1;
  end
endmodule : breaker_objects
`default_nettype wire

// file: verification/test_synchrocheck_stage_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_synchrocheck_stage_control;
  import match_ctrl_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid, wvalid, arvalid, blk, fen, nma;
  logic side, spin, awready, wready, bvalid, arready, rvalid, lir, ta, tw;
  logic tb, ara;
  logic [1:0] bresp, rresp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [33:0] q[$];
  logic [2:0] sync, start, prm, sblk;
  logic [4:0] cmd;
  logic signed [19:0] ang;
  int closes [5], fails = 0, comparisons = 0, cyc = 0, seed = 22;
  always #5 aclk = ~aclk;
  synchrocheck_stage_control #(.CYCLE_CLKS(4)) synchrocheck_stage_control_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready(1'h1), .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready(1'h1), .block_input(blk),
    .sync_reached(sync), .check_start_input(start), .all_refs_allowed(ara),
    .ch3_side_channel(side), .ch4_side_channel(side), .node_mode_allowed(nma),
    .forcing_enable(fen), .angle_mdeg(ang), .match_permit(prm),
    .stage_blocked(sblk), .line_is_reference(lir), .close_object_cmd(cmd));
  breaker_objects breaker_objects_i (.aclk, .close_cmd(cmd), .closes);
  task chk(input string n, input logic [33:0] e, s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  always @(posedge aclk) begin
    cyc++;
    if (rvalid) chk("rdata", q.pop_front(), {rresp, rdata});
    if (spin && cyc % 4 == 0) ang <= 20'($random(seed) % 80000);
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
    do begin
      @(negedge aclk);
      {ta, tw, tb} = {awready, wready, bvalid};
      if (tb) chk("bresp", 34'(RESP_OKAY), 34'(bresp));
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!tb);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back({(a > OFS_ANGLE) ? RESP_SLVERR : RESP_OKAY, e});
    @(posedge aclk);
    {araddr, arvalid} <= {a, 1'h1};
    do begin
      @(negedge aclk);
      ta = arready;
      @(posedge aclk);
    end while (!ta);
    arvalid <= 1'h0;
  endtask : rd
  task step(input logic [7:0] a, input logic [31:0] d, input logic [6:0] i,
      input int n, input logic [31:0] e);
    wr(a, d);
    {sync, start, blk} <= i;
    repeat (n) @(posedge aclk);
    rd(OFS_STATUS, e);
  endtask : step
  initial begin
    {awvalid, wvalid, arvalid, blk, fen, sync, start, awaddr, araddr} <= '0;
    {wdata, ang, nma, side, spin, ara} <= {52'h0, 4'hf};
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    chk("line_ref", 32'h1, 32'(lir));
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_DELAY, 32'h0000_000A);
    rd(8'h40, 32'h0);
    step(OFS_CTRL, 32'h0000_0100, 7'h70, 20, 32'h0);
    chk("line_ref", 32'h0, 32'(lir));
    step(OFS_STAGE, 32'h0000_0111, 7'h70, 20, 32'h0);
    step(OFS_STAGE, 32'h0000_0111, 7'h72, 20, 32'h0000_0101);
    step(OFS_CTRL, 32'h0, 7'h73, 20, 32'h0000_0110);
    step(OFS_CTRL, 32'h0000_0010, 7'h72, 20, 32'h0000_0100);
    step(OFS_CTRL, 32'h0000_0010, 7'h72, 40, 32'h0000_0101);
    step(OFS_CTRL, 32'h0000_0020, 7'h02, 10, 32'h0000_0100);
    step(OFS_CTRL, 32'h0000_0020, 7'h72, 12, 32'h0000_0101);
    step(OFS_CTRL, 32'h0000_0020, 7'h72, 40, 32'h0000_0100);
    {sync, fen} <= 4'h1;
    for (int c = 1; c < 7; c++) begin
      wr(OFS_CTRL, 32'(c) << 12);
      @(negedge aclk);
      chk("blocked", 32'(c[0]) << ((c - 1) / 2), 32'(sblk));
      chk("permit", 32'(!c[0]) << ((c - 1) / 2), 32'(prm));
    end
    {fen, spin} <= 2'h0;
    step(OFS_STAGE, 32'h0210_0101, 7'h10, 200, 32'h0000_1101);
    chk("close_obj", 32'h1, 32'(closes[2]));
    step(OFS_CTRL, 32'h0000_0004, 7'h10, 20, 32'h0000_1000);
    ara <= 1'h0;
    wr(OFS_STAGE, 32'h0000_0401);
    rd(OFS_STAGE, 32'h0000_0101);
    repeat (2) @(posedge aclk);
    tally_and_finish;
  end
endmodule : test_synchrocheck_stage_control
`default_nettype wire
